/* File: core/adcc_pkg.sv */
/*
 * adcc_pkg: register indices, field positions, reset values and codes
 * for the converter control shell.
 * Assumes register index n sits at byte address 4*n on the register bus.
 */
package adcc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_A = 8'h00;
  localparam logic [7:0] IDX_CLOCK_DIVIDER_CTL = 8'h01;
  localparam logic [7:0] IDX_TIMEBASE_REFERENCE_CTL = 8'h02;
  localparam logic [7:0] IDX_WINDOW_CTL = 8'h03;
  localparam logic [7:0] IDX_INTERRUPT_ENABLES = 8'h04;
  localparam logic [7:0] IDX_INTERRUPT_FLAGS = 8'h05;
  localparam logic [7:0] IDX_BUSY_STATUS = 8'h06;
  localparam logic [7:0] IDX_DEBUG_CTL = 8'h07;
  localparam logic [7:0] IDX_SAMPLE_DURATION_CTL = 8'h08;
  localparam logic [7:0] IDX_ACCUMULATION_CTL = 8'h09;
  localparam logic [7:0] IDX_CONVERSION_COMMAND = 8'h0A;
  localparam logic [7:0] IDX_AMPLIFIER_CTL = 8'h0B;
  localparam logic [7:0] IDX_POSITIVE_INPUT_SELECT = 8'h0C;
  localparam logic [7:0] IDX_NEGATIVE_INPUT_SELECT = 8'h0D;
  localparam logic [7:0] IDX_CONVERSION_RESULT = 8'h10;
  localparam logic [7:0] IDX_LAST_SAMPLE = 8'h14;
  localparam logic [7:0] IDX_SCRATCH_BYTE_0 = 8'h18;
  localparam logic [7:0] IDX_SCRATCH_BYTE_1 = 8'h19;
  localparam logic [7:0] IDX_SCRATCH_BYTE_2 = 8'h1A;
  localparam logic [7:0] IDX_WINDOW_LOW_THRESHOLD = 8'h1C;
  localparam logic [7:0] IDX_WINDOW_HIGH_THRESHOLD = 8'h1E;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CA_ENABLE = 0;
  localparam int CA_KEEP_ANALOG_ON = 5;
  localparam int CA_RUN_IN_STANDBY = 7;
  localparam int WC_SOURCE_SELECT = 3;
  localparam int DBG_RUN_WHEN_HALTED = 0;
  localparam int AF_FREE_RUN = 5;
  localparam int FL_RESULT_READY = 0;
  localparam int FL_SAMPLE_READY = 1;
  localparam int FL_WINDOW_MATCH = 2;
  localparam int FL_RESULT_OVERWRITE = 3;
  localparam int FL_SAMPLE_OVERWRITE = 4;
  localparam int FL_TRIGGER_COLLISION = 5;
  localparam int NUM_FLAGS = 6;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] START_STOP = 3'h0;
  localparam logic [2:0] START_IMMEDIATE = 3'h1;
  localparam logic [2:0] START_EVENT_TRIGGER = 3'h2;
  localparam logic [2:0] WCM_NONE = 3'h0;
  localparam logic [2:0] WCM_BELOW = 3'h1;
  localparam logic [2:0] WCM_ABOVE = 3'h2;
  localparam logic [2:0] WCM_INSIDE = 3'h3;
  localparam logic [2:0] WCM_OUTSIDE = 3'h4;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ADCC_IDLE, ADCC_BUSY} adcc_state_e;
endpackage : adcc_pkg

/* File: core/adcc_ctrl.sv */
/*
 * adcc_ctrl: digital control shell of the converter: register file on
 * AXI4-Lite, start and trigger handling, ready / overwrite / window
 * flags, event pulses, interrupt requests, sleep and debug gating.
 * Assumes the analog core outside converts on analog_start, reports each
 * sample on analog_sample_valid and the final output on
 * analog_result_valid (the last one of a conversion), and that all
 * inputs are synchronous to aclk.
 */
// Behaviour
// R01: one-cycle events equal to their flag conditions
// R02: event starts only with event-trigger start setting
// R03: trigger while busy sets collision flag
// R04: new sample over unread sample flags error
// R05: new result over unread result flags error
// R06: sample ready flag on new sample
// R07: result ready flag on new result
// R08: window flag per source and compare mode
// R09: conditions set flags; one enable per source
// R10: request while enabled and flagged, until cleared
// R11: idle/standby entry lets running conversion finish
// R12: idle takes events; standby only with run_in_standby
// R13: standby keeps analog powered with both bits
// R14: power-down aborts conversion immediately
// R15: debug halt with run_when_halted keeps running
// R16: debug halt otherwise finishes, then halts
// R17: window on result low half or sample
// R18: result window at end, sample window each
// R19: flags clear by writing one, zero ignored
// R20: busy from start until outputs written
`timescale 1ns/100ps
module adcc_ctrl
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system state
  input wire logic sleep_idle,
  input wire logic sleep_standby,
  input wire logic sleep_power_down,
  input wire logic debug_halt,
  // event routing
  input wire logic start_event,
  output logic per_conversion_event,
  output logic conversion_done_event,
  output logic window_match_event,
  // interrupt vectors
  output logic irq_error,
  output logic irq_sample_ready,
  output logic irq_result_ready,
  // analog core
  output logic analog_start,
  output logic analog_abort,
  output logic analog_power,
  input wire logic analog_sample_valid,
  input wire logic [15:0] analog_sample,
  input wire logic analog_result_valid,
  input wire logic [31:0] analog_result
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] control_a;
    logic [7:0] clock_divider_ctl;
    logic [7:0] timebase_reference_ctl;
    logic [7:0] window_ctl;
    logic [7:0] interrupt_enables;
    logic [NUM_FLAGS-1:0] interrupt_flags;
    logic [7:0] debug_ctl;
    logic [7:0] sample_duration_ctl;
    logic [7:0] accumulation_ctl;
    logic [7:0] conversion_command;
    logic [7:0] amplifier_ctl;
    logic [7:0] positive_input_select;
    logic [7:0] negative_input_select;
    logic [7:0] scratch_byte_0;
    logic [7:0] scratch_byte_1;
    logic [7:0] scratch_byte_2;
    logic [15:0] window_low_threshold;
    logic [15:0] window_high_threshold;
    logic [31:0] conversion_result;
    logic [15:0] last_sample;
    logic sample_unread;
    logic result_unread;
    adcc_state_e state;
    logic event_prev;
    logic per_conversion_event;
    logic conversion_done_event;
    logic window_match_event;
    logic irq_error;
    logic irq_sample_ready;
    logic irq_result_ready;
    logic analog_start;
    logic analog_abort;
    logic analog_power;
  } adcc_state_s;

  adcc_state_s st;
  adcc_state_s next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = {2'h0, addr[ADDR_W-1:2]};
  endfunction : reg_index

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
  endfunction : merge16

  function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] v,
                                      input logic [15:0] lo, input logic [15:0] hi);
    unique case (mode)
      WCM_BELOW: window_hit = v < lo;
      WCM_ABOVE: window_hit = v > hi;
      WCM_INSIDE: window_hit = (v > lo) && (v < hi);
      WCM_OUTSIDE: window_hit = (v < lo) || (v > hi);
      default: window_hit = 1'b0;
    endcase
  endfunction : window_hit

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [31:0] rd;
    logic mapped;
    logic enabled;
    logic standby_run;
    logic halted;
    logic ev_ok;
    logic ev_edge;
    logic sw_trig;
    logic ev_trig;
    logic fr_trig;
    logic trig;
    logic win_src_sample;
    logic win_hit;
    logic [NUM_FLAGS-1:0] set_f;
    logic [NUM_FLAGS-1:0] clr_f;
    logic [NUM_FLAGS-1:0] act;
    do_write = 1'b0;
    do_read = 1'b0;
    widx = 8'h00;
    ridx = 8'h00;
    rd = 32'h0000_0000;
    mapped = 1'b0;
    set_f = '0;
    clr_f = '0;
    {enabled, standby_run, halted, ev_ok, ev_edge, sw_trig, ev_trig, fr_trig, trig} = '0;
    {win_src_sample, win_hit, act} = '0;
    next_st = st;
    next_st.per_conversion_event = 1'b0;
    next_st.conversion_done_event = 1'b0;
    next_st.window_match_event = 1'b0;
    next_st.analog_start = 1'b0;
    next_st.analog_abort = 1'b0;

    // -------------------------------------------------------------
    // bus write: address and data taken in either order
    // -------------------------------------------------------------
    if (s_axi_awvalid && st.awready) begin
      next_st.have_aw = 1'b1;
      next_st.waddr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.have_w = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.have_aw && st.have_w && !st.bvalid) begin
      do_write = 1'b1;
      widx = reg_index(st.waddr);
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (do_write) begin
      unique case (widx)
        IDX_CONTROL_A: if (st.wstrb[0]) next_st.control_a = st.wdata[7:0];
        IDX_CLOCK_DIVIDER_CTL: if (st.wstrb[0]) next_st.clock_divider_ctl = st.wdata[7:0];
        IDX_TIMEBASE_REFERENCE_CTL:
          if (st.wstrb[0]) next_st.timebase_reference_ctl = st.wdata[7:0];
        IDX_WINDOW_CTL: if (st.wstrb[0]) next_st.window_ctl = st.wdata[7:0];
        IDX_INTERRUPT_ENABLES: if (st.wstrb[0]) next_st.interrupt_enables = st.wdata[7:0];
        IDX_INTERRUPT_FLAGS:
          if (st.wstrb[0]) clr_f = st.wdata[NUM_FLAGS-1:0]; // see R19
        IDX_DEBUG_CTL: if (st.wstrb[0]) next_st.debug_ctl = st.wdata[7:0];
        IDX_SAMPLE_DURATION_CTL: if (st.wstrb[0]) next_st.sample_duration_ctl = st.wdata[7:0];
        IDX_ACCUMULATION_CTL: if (st.wstrb[0]) next_st.accumulation_ctl = st.wdata[7:0];
        IDX_CONVERSION_COMMAND: if (st.wstrb[0]) next_st.conversion_command = st.wdata[7:0];
        IDX_AMPLIFIER_CTL: if (st.wstrb[0]) next_st.amplifier_ctl = st.wdata[7:0];
        IDX_POSITIVE_INPUT_SELECT:
          if (st.wstrb[0]) next_st.positive_input_select = st.wdata[7:0];
        IDX_NEGATIVE_INPUT_SELECT:
          if (st.wstrb[0]) next_st.negative_input_select = st.wdata[7:0];
        IDX_SCRATCH_BYTE_0: if (st.wstrb[0]) next_st.scratch_byte_0 = st.wdata[7:0];
        IDX_SCRATCH_BYTE_1: if (st.wstrb[0]) next_st.scratch_byte_1 = st.wdata[7:0];
        IDX_SCRATCH_BYTE_2: if (st.wstrb[0]) next_st.scratch_byte_2 = st.wdata[7:0];
        IDX_WINDOW_LOW_THRESHOLD:
          next_st.window_low_threshold = merge16(st.window_low_threshold, st.wdata, st.wstrb);
        IDX_WINDOW_HIGH_THRESHOLD:
          next_st.window_high_threshold = merge16(st.window_high_threshold, st.wdata, st.wstrb);
        IDX_BUSY_STATUS, IDX_CONVERSION_RESULT, IDX_LAST_SAMPLE: ;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // -------------------------------------------------------------
    // bus read: one cycle after the address is taken
    // -------------------------------------------------------------
    if (s_axi_arvalid && st.arready) begin
      do_read = 1'b1;
      ridx = reg_index(s_axi_araddr);
      next_st.arready = 1'b0;
    end
    if (do_read) begin
      mapped = 1'b1;
      unique case (ridx)
        IDX_CONTROL_A: rd[7:0] = st.control_a;
        IDX_CLOCK_DIVIDER_CTL: rd[7:0] = st.clock_divider_ctl;
        IDX_TIMEBASE_REFERENCE_CTL: rd[7:0] = st.timebase_reference_ctl;
        IDX_WINDOW_CTL: rd[7:0] = st.window_ctl;
        IDX_INTERRUPT_ENABLES: rd[7:0] = st.interrupt_enables;
        IDX_INTERRUPT_FLAGS: rd[NUM_FLAGS-1:0] = st.interrupt_flags;
        IDX_BUSY_STATUS: rd[0] = (st.state == ADCC_BUSY); // see R20
        IDX_DEBUG_CTL: rd[7:0] = st.debug_ctl;
        IDX_SAMPLE_DURATION_CTL: rd[7:0] = st.sample_duration_ctl;
        IDX_ACCUMULATION_CTL: rd[7:0] = st.accumulation_ctl;
        IDX_CONVERSION_COMMAND: rd[7:0] = st.conversion_command;
        IDX_AMPLIFIER_CTL: rd[7:0] = st.amplifier_ctl;
        IDX_POSITIVE_INPUT_SELECT: rd[7:0] = st.positive_input_select;
        IDX_NEGATIVE_INPUT_SELECT: rd[7:0] = st.negative_input_select;
        IDX_CONVERSION_RESULT: rd = st.conversion_result;
        IDX_LAST_SAMPLE: rd[15:0] = st.last_sample;
        IDX_SCRATCH_BYTE_0: rd[7:0] = st.scratch_byte_0;
        IDX_SCRATCH_BYTE_1: rd[7:0] = st.scratch_byte_1;
        IDX_SCRATCH_BYTE_2: rd[7:0] = st.scratch_byte_2;
        IDX_WINDOW_LOW_THRESHOLD: rd[15:0] = st.window_low_threshold;
        IDX_WINDOW_HIGH_THRESHOLD: rd[15:0] = st.window_high_threshold;
        default: mapped = 1'b0;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = mapped ? RESP_OKAY : RESP_SLVERR;
      // reading a value marks it as seen by software
      if (ridx == IDX_CONVERSION_RESULT) next_st.result_unread = 1'b0;
      if (ridx == IDX_LAST_SAMPLE) next_st.sample_unread = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // -------------------------------------------------------------
    // start gating by sleep and debug state
    // -------------------------------------------------------------
    enabled = st.control_a[CA_ENABLE];
    standby_run = st.control_a[CA_RUN_IN_STANDBY];
    // a halt only blocks event and free-run starts, not software starts, so a running conversion completes
    halted = (sleep_standby && !standby_run) // see R11
             || (debug_halt && !st.debug_ctl[DBG_RUN_WHEN_HALTED]); // see R15 R16
    ev_ok = enabled && !sleep_power_down && !halted; // see R12
    ev_edge = start_event && !st.event_prev;
    next_st.event_prev = start_event;
    sw_trig = do_write && (widx == IDX_CONVERSION_COMMAND) && st.wstrb[0]
              && (st.wdata[2:0] == START_IMMEDIATE) && enabled && !sleep_power_down;
    ev_trig = ev_edge && (st.conversion_command[2:0] == START_EVENT_TRIGGER)
              && ev_ok; // see R02
    fr_trig = analog_result_valid && (st.state == ADCC_BUSY)
              && st.accumulation_ctl[AF_FREE_RUN] && ev_ok;
    trig = sw_trig || ev_trig;

    // -------------------------------------------------------------
    // conversion sequence
    // -------------------------------------------------------------
    unique case (st.state)
      ADCC_IDLE: begin
        if (trig) begin
          next_st.state = ADCC_BUSY; // see R20
          next_st.analog_start = 1'b1;
        end
      end
      ADCC_BUSY: begin
        if (trig) set_f[FL_TRIGGER_COLLISION] = 1'b1; // see R03
        if (analog_result_valid && !fr_trig) next_st.state = ADCC_IDLE; // see R20
        if (fr_trig) next_st.analog_start = 1'b1;
      end
    endcase
    if (sleep_power_down && st.state == ADCC_BUSY) begin
      // partial outputs are dropped; no flag is raised for them
      next_st.state = ADCC_IDLE; // see R14
      next_st.analog_abort = 1'b1;
    end

    // -------------------------------------------------------------
    // outputs of a conversion
    // -------------------------------------------------------------
    win_src_sample = st.window_ctl[WC_SOURCE_SELECT];
    win_hit = 1'b0;
    if (analog_sample_valid && st.state == ADCC_BUSY && !sleep_power_down) begin
      next_st.last_sample = analog_sample;
      next_st.sample_unread = 1'b1;
      set_f[FL_SAMPLE_READY] = 1'b1; // see R06
      if (st.sample_unread) set_f[FL_SAMPLE_OVERWRITE] = 1'b1; // see R04
      if (win_src_sample) begin
        win_hit = window_hit(st.window_ctl[2:0], analog_sample,
                             st.window_low_threshold, st.window_high_threshold); // see R17 R18
      end
    end
    if (analog_result_valid && st.state == ADCC_BUSY && !sleep_power_down) begin
      next_st.conversion_result = analog_result;
      next_st.result_unread = 1'b1;
      set_f[FL_RESULT_READY] = 1'b1; // see R07
      if (st.result_unread) set_f[FL_RESULT_OVERWRITE] = 1'b1; // see R05
      if (!win_src_sample) begin
        win_hit = window_hit(st.window_ctl[2:0], analog_result[15:0],
                             st.window_low_threshold, st.window_high_threshold); // see R17 R18
      end
    end
    set_f[FL_WINDOW_MATCH] = win_hit; // see R08

    // -------------------------------------------------------------
    // flags, events and requests
    // -------------------------------------------------------------
    // a set in the same cycle as a clear wins
    next_st.interrupt_flags = (st.interrupt_flags & ~clr_f) | set_f; // see R09 R19
    next_st.per_conversion_event = set_f[FL_SAMPLE_READY]; // see R01
    next_st.conversion_done_event = set_f[FL_RESULT_READY]; // see R01
    next_st.window_match_event = set_f[FL_WINDOW_MATCH]; // see R01
    act = next_st.interrupt_flags & next_st.interrupt_enables[NUM_FLAGS-1:0]; // see R10
    next_st.irq_error = act[FL_TRIGGER_COLLISION] || act[FL_SAMPLE_OVERWRITE]
                        || act[FL_RESULT_OVERWRITE];
    next_st.irq_sample_ready = act[FL_SAMPLE_READY]
                               || (act[FL_WINDOW_MATCH] && win_src_sample); // see R17
    next_st.irq_result_ready = act[FL_RESULT_READY]
                               || (act[FL_WINDOW_MATCH] && !win_src_sample); // see R17

    // analog power: kept on between conversions only with keep_analog_on,
    // and in standby only when run_in_standby is also set
    next_st.analog_power = enabled && !sleep_power_down
                           && ((next_st.state == ADCC_BUSY)
                               || (st.control_a[CA_KEEP_ANALOG_ON]
                                   && (!sleep_standby || standby_run))); // see R13 R14

    if (!aresetn) begin
      next_st = '0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
      next_st.state = ADCC_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign per_conversion_event = st.per_conversion_event;
  assign conversion_done_event = st.conversion_done_event;
  assign window_match_event = st.window_match_event;
  assign irq_error = st.irq_error;
  assign irq_sample_ready = st.irq_sample_ready;
  assign irq_result_ready = st.irq_result_ready;
  assign analog_start = st.analog_start;
  assign analog_abort = st.analog_abort;
  assign analog_power = st.analog_power;

endmodule : adcc_ctrl

/* File: tb/adcc_core_model.sv */
/* adcc_core_model: behavioural analog core, one sample then one result per start.
   assumes start and abort are single-cycle pulses on aclk. */
`timescale 1ns/100ps
module adcc_core_model (
  // clock and control
  input wire logic aclk,
  input wire logic analog_start,
  input wire logic analog_abort,
  // value and pacing chosen by the bench
  input wire logic [15:0] val,
  input wire logic [3:0] dly,
  // answers
  output logic analog_sample_valid,
  output logic [15:0] analog_sample,
  output logic analog_result_valid,
  output logic [31:0] analog_result
);
  // ----------
  // pacing
  // ----------
  int cnt = 0;
  initial analog_sample_valid = 1'h0;
  initial analog_result_valid = 1'h0;
  always @(posedge aclk) begin
    analog_sample_valid <= cnt == 2;
    analog_result_valid <= cnt == 1;
    if (analog_abort) cnt <= 0;
    else if (analog_start) cnt <= dly + 2;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // off-pulse lines show the inverse so a stale value never matches
  assign analog_sample = analog_sample_valid ? val : ~val;
  assign analog_result = analog_result_valid ? {16'h0, val} : ~{16'h0, val};
endmodule : adcc_core_model

/* File: tb/adcc_ctrl_assertions.sv */
/* adcc_checker: port timing of adcc_ctrl.
   assumes the single clock aclk and synchronous aresetn. */
`timescale 1ns/100ps
module adcc_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // conversion and events
  input wire logic sleep_power_down,
  input wire logic analog_start,
  input wire logic analog_abort,
  input wire logic analog_sample_valid,
  input wire logic analog_result_valid,
  input wire logic per_conversion_event,
  input wire logic conversion_done_event,
  input wire logic irq_error
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_irq_drop;
    irq_error ##1 !irq_error;
  endsequence
  a_write_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_done_cause: assert property (conversion_done_event |-> $past(analog_result_valid))
    else $error("result event without result");
  a_sample_cause: assert property (per_conversion_event |-> $past(analog_sample_valid))
    else $error("sample event without sample");
  a_abort_cause: assert property (analog_abort |-> $past(sleep_power_down))
    else $error("abort without power-down");
  a_abort_quiet: assert property (analog_abort |-> !conversion_done_event [*4])
    else $error("result after abort");
  a_no_start_pd: assert property ($past(sleep_power_down) |-> !analog_start)
    else $error("start in power-down");
  a_irq_hold: assert property (s_irq_drop |-> $rose(s_axi_bvalid))
    else $error("request dropped without a write");
endmodule : adcc_checker
bind adcc_ctrl adcc_checker adcc_checker_i (.*);

/* File: tb/testbench.sv */
/* testbench: adcc_ctrl over axi4-lite against an integer flag model.
   assumes adcc_core_model answers every analog start. */
`timescale 1ns/100ps
module testbench;
  import adcc_pkg::*;
  // ----------
  // signals and model state
  // ----------
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_idle = 0, sleep_standby = 0;
  logic sleep_power_down = 0, debug_halt = 0, start_event = 0, h, w;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, analog_result, d;
  logic [3:0] s_axi_wstrb = 4'hF, dly = 4'h2;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] analog_sample, val = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic per_conversion_event, conversion_done_event, window_match_event, irq_error;
  logic irq_sample_ready, irq_result_ready, analog_start, analog_abort, analog_power;
  logic analog_sample_valid, analog_result_valid;
  int errors = 0, check_count = 0, flags = 0, su = 0, ru = 0, lo, hi, m, n;
  always #10 aclk = ~aclk;
  adcc_ctrl adcc_ctrl_i (.*);
  adcc_core_model adcc_core_model_i (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task tally_and_finish;
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // sampled at negedge: values equal those at the next rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic [2:0] g;
    g = 3'h0;
    s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= v; s_axi_awvalid <= wr;
    s_axi_wvalid <= wr; s_axi_bready <= wr; s_axi_arvalid <= !wr; s_axi_rready <= !wr;
    for (n = 0; n < 40 && !g[2]; n++) begin
      @(negedge aclk);
      g = {wr ? s_axi_bvalid : s_axi_rvalid, wr ? s_axi_awready : s_axi_arready, s_axi_wready};
      r = wr ? s_axi_bresp : s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (g[1]) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
      if (g[0]) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0; s_axi_rready <= 0;
    chk(g[2], 1);
    if (!g[2]) tally_and_finish;
    chk(r, e);
    @(posedge aclk);
  endtask : bus
  function int win(input int v);
    return m == 1 ? v < lo : m == 2 ? v > hi : m == 3 ? v > lo && v < hi : m == 4 ? v < lo || v > hi : 0;
  endfunction : win
  // k=1 waits for the result event, k=0 for an abort
  task await(input int k);
    h = 0;
    for (n = 0; n < 60 && !h; n++) begin
      @(negedge aclk); h = k ? conversion_done_event : analog_abort; w = window_match_event;
    end
    chk(h, 1);
    if (!h) tally_and_finish;
    if (k) chk(w, win(val));
    if (k) flags |= 3 | win(val) << 2 | ru << 3 | su << 4;
    if (k) begin su = 1; ru = 1; end
    @(posedge aclk);
  endtask : await
  task pulse;
    start_event <= 1; @(posedge aclk); start_event <= 0; @(posedge aclk);
  endtask : pulse
  // ----------
  // scenarios
  // ----------
  initial begin
    d = $urandom(1067);
    repeat (5) @(posedge aclk);
    aresetn <= 1; @(posedge aclk);
    bus(0, 8'h3C, 0, RESP_SLVERR); chk(d, 0);
    lo = $urandom_range(32767); hi = lo + 16384;
    bus(1, 8'h70, lo, RESP_OKAY); bus(1, 8'h78, hi, RESP_OKAY); bus(1, 8'h00, 1, RESP_OKAY);
    bus(1, 8'h10, 8'h3F, RESP_OKAY); bus(0, 8'h10, 0, RESP_OKAY); chk(d, 8'h3F);
    for (m = 1; m < 6; m++) begin
      val <= 16'($urandom); bus(1, 8'h0C, m, RESP_OKAY); bus(1, 8'h28, 1, RESP_OKAY); await(1);
      chk(irq_error, (flags & 8'h38) != 0); chk(irq_result_ready, (flags & 5) != 0);
      chk(irq_sample_ready, (flags & 2) != 0);
      if (m[0]) begin bus(0, 8'h40, 0, RESP_OKAY); chk(d, val); ru = 0; end
      if (m[1]) begin bus(0, 8'h50, 0, RESP_OKAY); chk(d, val); su = 0; end
      bus(1, 8'h14, 0, RESP_OKAY); bus(0, 8'h14, 0, RESP_OKAY); chk(d, flags);
      bus(1, 8'h14, 8'h3F, RESP_OKAY); flags = 0;
    end
    bus(1, 8'h28, 2, RESP_OKAY); sleep_standby <= 1; pulse;
    bus(0, 8'h18, 0, RESP_OKAY); chk(d, 0);
    sleep_standby <= 0; sleep_idle <= 1; pulse;
    bus(0, 8'h18, 0, RESP_OKAY); chk(d, 1); chk(analog_power, 1);
    await(1);
    dly <= 4'hF; pulse; pulse; flags |= 8'h20; debug_halt <= 1; await(1);
    debug_halt <= 0; bus(0, 8'h14, 0, RESP_OKAY); chk(d, flags); chk(irq_error, 1);
    bus(1, 8'h14, 8'h3F, RESP_OKAY); pulse; sleep_power_down <= 1; await(0);
    sleep_power_down <= 0; bus(0, 8'h18, 0, RESP_OKAY); chk(d, 0);
    bus(0, 8'h14, 0, RESP_OKAY); chk(d, 0); chk(analog_power, 0);
    tally_and_finish;
  end
endmodule : testbench
